// ==== core/inc_mem_pkg.sv ====
// shared constants and types of the increment memory controller
package inc_mem_pkg;
  // bus address width toward the i/o processor
  localparam int ADDR_W = 15;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // command register field: clear-flag instruction
  localparam int CMD_CLEAR_FLAG = 0;
  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // timing: core clock and bus sync pulse period
  localparam int CLK_MHZ = 250;
  localparam int SYNC_PERIOD_NS = 1000;
  localparam int SYNC_PERIOD_CYC = SYNC_PERIOD_NS * CLK_MHZ / 1000;
  localparam int SYNC_LOST_CYC = 2 * SYNC_PERIOD_CYC;
  // default local tick period
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_PERIOD_CYC = TICK_PERIOD_US * CLK_MHZ;
  // control register layout, bit 0 lowest
  typedef struct packed {
    logic useProgInt;
    logic tickEnable;
    logic countEnable;
  } ctrl_type;
  // interrupt status and mask layout
  typedef struct packed {
    logic syncLost;
    logic tickLost;
    logic cycleDone;
    logic overflow;
  } irq_type;
  // bus pins coming in from the i/o processor side
  typedef struct packed {
    logic powerClear;
    logic syncPulse;
    logic grant;
    logic overflow;
    logic chanEnIn;
    logic priEnIn;
  } bus_in_type;
  // channel sequence states
  typedef enum logic [1:0] {CH_IDLE, CH_REQUEST, CH_ACTIVE} chan_state_type;
endpackage : inc_mem_pkg

// ==== core/pin_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins and synchronised levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] stage1_q;

  // first stage is read only by the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_q <= '0;
      pinOut <= '0;
    end else begin
      stage1_q <= pinIn;
      pinOut <= stage1_q;
    end
  end
endmodule : pin_sync

// ==== core/tick_divider.sv ====
// local tick clock: one-cycle enable pulse every period cycles
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [W-1:0] period,
  // tick enable pulse
  output logic tick
);
  logic [W-1:0] count_q;
  wire logic atEnd = (count_q >= period - 1'b1) || (period == '0);

  // restart from zero whenever the clock is stopped
  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      count_q <= '0;
      tick <= 1'b0;
    end else begin
      count_q <= atEnd ? '0 : count_q + 1'b1;
      tick <= atEnd;
    end
  end
endmodule : tick_divider

// ==== core/increment_memory_controller.sv ====
// increment memory controller: tick, channel request chain, overflow flag, apb registers
//
// What this block does
// - The count only starts under software control, with count enable and tick clock set.
// - A pending tick request sets the channel request latch on a sync pulse edge only.
// - The request latch drives the active-low request line and a grant makes the channel active.
// - While active, the target address is driven out and the increment line is pulled low.
// - The processor pulses overflow on wrap to zero and the overflow flag sets on it.
// - A set overflow flag raises a priority level 0 request or a program interrupt request.
// - There is no data bus, data register or transmit path in this block.
// - The channel enable is passed on down the chain and a request posts only while it is in.
// - Posting a request drops the outgoing channel enable at once, cutting lower devices.
// - The priority request posts only with priority enable in, and then drops enable out.
// - The clear-flag command clears overflow flag and priority request; status tests the flag.
// - The bus power clear pulse returns every flag and latch to its initial state.
// - The target address is presented on fifteen address lines toward the processor.
`timescale 1ns/1ps
module increment_memory_controller
  import inc_mem_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_PERIOD_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt to the local host
  output logic irq,
  // i/o bus inputs, asynchronous
  input wire logic syncPulse,
  input wire logic channelGrant,
  input wire logic overflowPulse,
  input wire logic busPowerClear,
  input wire logic channelEnableIn,
  input wire logic priorityEnableIn,
  // i/o bus outputs
  output logic channelRequestLine_n,
  output logic channelEnableOut,
  output logic incrementMemoryLine_n,
  output logic [ADDR_W-1:0] busAddr,
  output logic priorityInterruptRequest_n,
  output logic priorityEnableOut,
  output logic programInterruptRequest_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  bus_in_type pinsS;
  logic syncPrev_q;
  logic ovfPrev_q;

  pin_sync #(.W($bits(bus_in_type))) u_pins (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({busPowerClear, syncPulse, channelGrant, overflowPulse,
            channelEnableIn, priorityEnableIn}),
    .pinOut(pinsS)
  );

  // edge detection reads only the second stage and later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncPrev_q <= 1'b0;
      ovfPrev_q <= 1'b0;
    end else begin
      syncPrev_q <= pinsS.syncPulse;
      ovfPrev_q <= pinsS.overflow;
    end
  end

  // sync timing
  // requests move only on the leading edge of the 1 us sync pulse
  wire logic syncEdge = pinsS.syncPulse && !syncPrev_q;
  wire logic ovfEdge = pinsS.overflow && !ovfPrev_q;
  // power clear
  // power clear from the bus acts like a second synchronous reset
  wire logic clearAll = rst || pinsS.powerClear;

  ////////////////////////////////////////////////////////////////////////////
  // apb register decode

  ctrl_type ctrl_q;
  logic [ADDR_W-1:0] targetAddr_q;
  logic [31:0] period_q;
  irq_type irqStat_q;
  irq_type irqMask_q;
  logic [31:0] rdData;

  wire logic apbSetup = psel && !penable;
  wire logic apbAccess = psel && penable;
  wire logic wrEn = apbAccess && pwrite;
  wire logic hitCtrl = (paddr == OFF_CTRL);
  wire logic hitStatus = (paddr == OFF_STATUS);
  wire logic hitAddr = (paddr == OFF_ADDR);
  wire logic hitPeriod = (paddr == OFF_PERIOD);
  wire logic hitCmd = (paddr == OFF_CMD);
  wire logic hitIrqStat = (paddr == OFF_IRQ_STAT);
  wire logic hitIrqMask = (paddr == OFF_IRQ_MASK);
  wire logic hitAny = hitCtrl || hitStatus || hitAddr || hitPeriod || hitCmd || hitIrqStat
                      || hitIrqMask;
  // clear flag
  // writing a one to the command bit acts as the clear-flag instruction
  wire logic clearCmd = wrEn && hitCmd && pwdata[CMD_CLEAR_FLAG];

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apbAccess && !hitAny;

  // software-written registers; power clear also stops the count
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      ctrl_q <= CTRL_RST;
      targetAddr_q <= ADDR_RST;
      irqMask_q <= IRQ_RST;
      period_q <= 32'(TICK_CYCLES);
    end else if (wrEn) begin
      if (hitCtrl) ctrl_q <= pwdata[2:0];
      if (hitAddr) targetAddr_q <= pwdata[ADDR_W-1:0];
      if (hitPeriod) period_q <= pwdata;
      if (hitIrqMask) irqMask_q <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local tick clock and tick request

  logic tick;
  logic tickReq_q;
  chan_state_type state_q;
  chan_state_type state_d;
  // program start
  // the tick clock runs only when software sets both enables
  wire logic runEnable = ctrl_q.countEnable && ctrl_q.tickEnable;

  tick_divider #(.W(32)) u_tick (
    .ref_clk(ref_clk),
    .rst(clearAll),
    .enable(runEnable),
    .period(period_q),
    .tick(tick)
  );

  wire logic cycleDone = (state_q == CH_ACTIVE) && !pinsS.grant;

  // tick request cleanup
  // a tick beats the end of a cycle; a tick that meets a stop write is dropped
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      tickReq_q <= 1'b0;
    end else if (tick && runEnable) begin
      tickReq_q <= 1'b1;
    end else if (cycleDone) begin
      tickReq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel request sequence

  always_comb begin
    state_d = state_q;
    case (state_q)
      CH_IDLE: begin
        if (syncEdge && tickReq_q && pinsS.chanEnIn) state_d = CH_REQUEST;
      end
      CH_REQUEST: begin
        if (pinsS.grant) state_d = CH_ACTIVE;
      end
      CH_ACTIVE: begin
        if (!pinsS.grant) state_d = CH_IDLE;
      end
      default: state_d = CH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (clearAll) state_q <= CH_IDLE;
    else state_q <= state_d;
  end

  wire logic chanReq = (state_q != CH_IDLE);
  wire logic chanActive = (state_q == CH_ACTIVE);

  // chain cut
  // the chain is cut from the request until the cycle ends
  assign channelRequestLine_n = !chanReq;
  assign channelEnableOut = pinsS.chanEnIn && !chanReq;

  // no data path
  // address lines carry zero when idle so a wired bus sees nothing from us
  assign busAddr = chanActive ? targetAddr_q : '0;
  assign incrementMemoryLine_n = !chanActive;

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag and interrupt requests

  logic overflowFlag_q;
  logic priReq_q;

  // overflow flag
  // an overflow in the clear cycle is kept; set beats clear
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      overflowFlag_q <= 1'b0;
    end else if (ovfEdge) begin
      overflowFlag_q <= 1'b1;
    end else if (clearCmd) begin
      overflowFlag_q <= 1'b0;
    end
  end

  // priority post
  // the request is timed to sync so it meets the processor's sampling window
  // a clear in the same cycle wins, or the request would outlive its flag
  wire logic priSet = syncEdge && overflowFlag_q && !clearCmd && !ctrl_q.useProgInt
                      && pinsS.priEnIn;

  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      priReq_q <= 1'b0;
    end else if (priSet) begin
      priReq_q <= 1'b1;
    end else if (clearCmd) begin
      priReq_q <= 1'b0;
    end
  end

  assign priorityInterruptRequest_n = !priReq_q;
  assign priorityEnableOut = pinsS.priEnIn && !priReq_q;
  assign programInterruptRequest_n = !(overflowFlag_q && ctrl_q.useProgInt);

  ////////////////////////////////////////////////////////////////////////////
  // sync watchdog and local interrupt

  logic [9:0] syncAge_q;
  wire logic syncLost = (syncAge_q == 10'(SYNC_LOST_CYC));

  // counts since the last sync edge; saturates one past the limit
  always_ff @(posedge ref_clk) begin
    if (clearAll || syncEdge) syncAge_q <= '0;
    else if (syncAge_q <= 10'(SYNC_LOST_CYC)) syncAge_q <= syncAge_q + 10'h001;
  end

  irq_type irqEvent;
  assign irqEvent = '{syncLost: syncLost, tickLost: tick && tickReq_q,
                      cycleDone: cycleDone, overflow: ovfEdge};
  wire irq_type irqW1c = (wrEn && hitIrqStat) ? irq_type'(pwdata[3:0]) : irq_type'(4'h0);

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk) begin
    if (clearAll) irqStat_q <= IRQ_RST;
    else irqStat_q <= (irqStat_q & ~irqW1c) | irqEvent;
  end

  assign irq = |(irqStat_q & irqMask_q);

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase

  // skip test
  // status bit 0 is the overflow flag that a skip test reads
  always_comb begin
    rdData = 32'h0000_0000;
    if (hitCtrl) rdData[2:0] = ctrl_q;
    if (hitStatus) rdData[4:0] = {priReq_q, chanActive, chanReq, tickReq_q, overflowFlag_q};
    if (hitAddr) rdData[ADDR_W-1:0] = targetAddr_q;
    if (hitPeriod) rdData = period_q;
    if (hitIrqStat) rdData[3:0] = irqStat_q;
    if (hitIrqMask) rdData[3:0] = irqMask_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (apbSetup && !pwrite) prdata <= rdData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (clearAll);

  sequence grantTaken;
    (state_q == CH_REQUEST) && pinsS.grant;
  endsequence

  sequence grantDropped;
    chanActive && !pinsS.grant;
  endsequence

  startGate_a: assert property ($rose(tickReq_q) |-> $past(runEnable))
    else $error("tick request set while count clock disabled");

  reqOnSync_a: assert property ($rose(chanReq) |-> $past(syncEdge) && $past(tickReq_q))
    else $error("channel request set away from sync edge");

  grantActive_a: assert property (grantTaken |=> chanActive && !channelRequestLine_n)
    else $error("grant did not make channel active");

  addrDrive_a: assert property (
    chanActive |-> !incrementMemoryLine_n && busAddr == targetAddr_q)
    else $error("address or increment line wrong while active");

  ovfFlag_a: assert property (ovfEdge |=> overflowFlag_q)
    else $error("overflow pulse did not set flag");

  progIrq_a: assert property (overflowFlag_q && ctrl_q.useProgInt |->
                              !programInterruptRequest_n && priorityInterruptRequest_n)
    else $error("program interrupt not raised for overflow");

  chainPost_a: assert property ($rose(chanReq) |-> $past(pinsS.chanEnIn))
    else $error("request posted without channel enable in");

  chainCut_a: assert property (chanReq |-> !channelEnableOut)
    else $error("channel enable out not dropped while requesting");

  priChain_a: assert property ($rose(priReq_q) |->
                               $past(pinsS.priEnIn) ##0 !priorityEnableOut)
    else $error("priority request chain rule broken");

  flagClear_a: assert property (clearCmd && !ovfEdge |=> !overflowFlag_q && !priReq_q)
    else $error("clear flag command did not clear");

  cycleEnd_a: assert property (grantDropped |=> !chanReq ##0 channelRequestLine_n)
    else $error("request not released after cycle");

  powerClr_a: assert property (@(posedge ref_clk) disable iff (rst)
                               pinsS.powerClear |=> !chanReq && !overflowFlag_q && !priReq_q
                               && !tickReq_q)
    else $error("power clear left a flag set");

endmodule : increment_memory_controller

// ==== bench/io_processor_model.sv ====
// i/o processor model: sync pulses, grant, memory increment, overflow
`timescale 1ns/1ps
module io_processor_model
  import inc_mem_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // from the controller
  input wire logic channelRequestLine_n,
  input wire logic incrementMemoryLine_n,
  input wire logic [ADDR_W-1:0] busAddr,
  // grant latency in cycles, set by the bench
  input wire logic [7:0] grantDelay,
  // to the controller
  output logic syncPulse,
  output logic channelGrant,
  output logic overflowPulse
);
  logic [17:0] mem [16];
  int syncCnt;
  ////////////////////////////////////////
  // one microsecond sync
  // 250 ns is 62.5 cycles, rounded down so the pulse never overlaps
  always @(posedge ref_clk) begin
    syncCnt <= (rst || syncCnt == SYNC_PERIOD_CYC - 1) ? 0 : syncCnt + 1;
    syncPulse <= !rst && syncCnt < 62;
  end
  // grant, increment, overflow
  // grant is dropped four cycles after the increment line goes low, then the model waits for the request line to let go
  initial begin
    foreach (mem[i]) mem[i] = 18'h0;
    channelGrant = 1'b0;
    overflowPulse = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (!rst && channelRequestLine_n === 1'b0) begin
        repeat (grantDelay) @(posedge ref_clk);
        channelGrant <= 1'b1;
        while (incrementMemoryLine_n !== 1'b0) @(posedge ref_clk);
        mem[busAddr[3:0]] = mem[busAddr[3:0]] + 18'h1;
        overflowPulse <= (mem[busAddr[3:0]] == 18'h0);
        repeat (4) @(posedge ref_clk);
        overflowPulse <= 1'b0;
        channelGrant <= 1'b0;
        while (channelRequestLine_n === 1'b0) @(posedge ref_clk);
      end
    end
  end
endmodule : io_processor_model

// ==== bench/increment_memory_controller_bench.sv ====
// self-checking bench of the increment memory controller
`timescale 1ns/1ps
module increment_memory_controller_bench
  import inc_mem_pkg::*;
;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, rdErr, reqPrev;
  logic [7:0] paddr, grantDelay;
  logic [31:0] pwdata, prdata, rdData;
  logic syncPulse, channelGrant, overflowPulse, busPowerClear;
  logic channelEnableIn, priorityEnableIn, channelRequestLine_n, channelEnableOut;
  logic incrementMemoryLine_n, priorityInterruptRequest_n, priorityEnableOut;
  logic programInterruptRequest_n;
  logic [ADDR_W-1:0] busAddr;
  int failCount, totalChecks;
  // short tick so default runs stay brief
  increment_memory_controller #(.TICK_CYCLES(20)) i_increment_memory_controller (
    .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq, .syncPulse, .channelGrant, .overflowPulse, .busPowerClear,
    .channelEnableIn, .priorityEnableIn, .channelRequestLine_n, .channelEnableOut,
    .incrementMemoryLine_n, .busAddr, .priorityInterruptRequest_n,
    .priorityEnableOut, .programInterruptRequest_n);
  io_processor_model i_io_processor_model (
    .ref_clk, .rst, .channelRequestLine_n, .incrementMemoryLine_n, .busAddr,
    .grantDelay, .syncPulse, .channelGrant, .overflowPulse);
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // apb transfer; the edge after release is let pass before returning
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic chkRd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rdData);
  endtask : chkRd
  task automatic waitInc(input logic v);
    while (incrementMemoryLine_n !== v) @(posedge ref_clk);
  endtask : waitInc
  // a request may only post inside a sync pulse, dropping the chain at once
  always @(posedge ref_clk) begin
    reqPrev <= channelRequestLine_n;
    if (reqPrev === 1'b1 && channelRequestLine_n === 1'b0) begin
      chk("sync at post", 1, syncPulse);
      chk("chain on post", 0, channelEnableOut);
    end
  end
  ////////////////////////////////////////
  task automatic test_reset;
    chkRd("ctrl", OFF_CTRL, 32'h0);
    chkRd("status", OFF_STATUS, 32'h0);
    chk("req line", 1, channelRequestLine_n);
    chk("inc line", 1, incrementMemoryLine_n);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 1, rdErr);
    chk("ready", 1, pready);
  endtask : test_reset
  task automatic test_idle;
    wr(OFF_CTRL, 32'h1);
    repeat (600) @(posedge ref_clk);
    chkRd("no tick", OFF_STATUS, 32'h0);
    chk("no request", 1, channelRequestLine_n);
  endtask : test_idle
  task automatic test_cycle;
    i_io_processor_model.mem[5] = 18'h3ffff;
    grantDelay <= 8'd40;
    wr(OFF_ADDR, 32'h5);
    wr(OFF_PERIOD, 32'h7d0);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'h3);
    waitInc(1'b0);
    chk("bus address", 5, busAddr);
    waitInc(1'b1);
    chk("req released", 1, channelRequestLine_n);
    repeat (SYNC_PERIOD_CYC + 10) @(posedge ref_clk);
    chkRd("flag and pri", OFF_STATUS, 32'h11);
    chk("pri request", 0, priorityInterruptRequest_n);
    chk("pri chain", 0, priorityEnableOut);
    chk("chain back", 1, channelEnableOut);
    chk("irq", 1, irq);
    chkRd("irq events", OFF_IRQ_STAT, 32'h3);
    wr(OFF_IRQ_MASK, 32'h0);
    chk("irq masked", 0, irq);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_IRQ_STAT, 32'hf);
    chk("irq cleared", 0, irq);
    chkRd("irq stat clear", OFF_IRQ_STAT, 32'h0);
    wr(OFF_CMD, 32'h1 << CMD_CLEAR_FLAG);
    chkRd("cleared", OFF_STATUS, 32'h0);
    chk("pri dropped", 1, priorityInterruptRequest_n);
    wr(OFF_CTRL, 32'h0);
  endtask : test_cycle
  task automatic test_prog;
    i_io_processor_model.mem[5] = 18'h3ffff;
    grantDelay <= 8'd2;
    wr(OFF_CTRL, 32'h7);
    waitInc(1'b0);
    waitInc(1'b1);
    repeat (8) @(posedge ref_clk);
    chk("prog int", 0, programInterruptRequest_n);
    chk("no pri", 1, priorityInterruptRequest_n);
    wr(OFF_CMD, 32'h1);
    chk("prog cleared", 1, programInterruptRequest_n);
    wr(OFF_CTRL, 32'h0);
  endtask : test_prog
  task automatic test_chain;
    channelEnableIn <= 1'b0;
    wr(OFF_PERIOD, 32'h1e);
    wr(OFF_CTRL, 32'h3);
    repeat (800) @(posedge ref_clk);
    chk("held request", 1, channelRequestLine_n);
    chk("chain passed", 0, channelEnableOut);
    chkRd("tick waits", OFF_STATUS, 32'h2);
    chkRd("tick lost", OFF_IRQ_STAT, 32'h7);
    channelEnableIn <= 1'b1;
    waitInc(1'b0);
  endtask : test_chain
  task automatic test_power_clear;
    busPowerClear <= 1'b1;
    repeat (70) @(posedge ref_clk);
    busPowerClear <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("pc inc", 1, incrementMemoryLine_n);
    chk("pc addr", 0, busAddr);
    chkRd("pc ctrl", OFF_CTRL, 32'h0);
    chkRd("pc status", OFF_STATUS, 32'h0);
    chkRd("pc irq stat", OFF_IRQ_STAT, 32'h0);
  endtask : test_power_clear
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // whole run is near 6.3k cycles; the 50k-cycle limit is several times that
  initial begin
    #200000;
    failCount++;
    $display("unexpected timeout expected done seen hung");
    tally_and_finish();
  end
  initial begin
    {rst, psel, penable, pwrite, busPowerClear} = 5'h10;
    {channelEnableIn, priorityEnableIn, paddr, pwdata} = {2'h3, 40'h0};
    grantDelay = 8'd2;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    test_reset();
    test_idle();
    test_cycle();
    test_prog();
    test_chain();
    test_power_clear();
    tally_and_finish();
  end
endmodule : increment_memory_controller_bench
